// ### verilog/adcsq_sequencer.sv
// Purpose: Power-up, configuration lock, sample-ready and offset-short sequencing
// Assumes: SPI mode 0; crystal, SCLK, CS and MOSI asynchronous to ref_clk
// Notes:   Samples enter through an 8-word FIFO that stalls its source
//
// How it works
// - Offset mode shorts and isolates current inputs
// - Short entry accepted in PWR_CTRL and PWR_RUN, ignored in PWR_WAIT
// - Waveform may jump at short transitions
// - Reset-complete flag set after 32 ms
// - Isolated side ready after 62 ms
// - Flowing flag set on first conversion
// - Sample-ready low for 256 crystal cycles
// - Shared pin defaults to sample-ready
// - Every transaction returns waves, statuses, CRC
// - Config bit 0 selects clock output
// - Reset-complete always drives interrupt low
`timescale 1ns/1ns
`include "adcsq_defs.svh"

module adcsq_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } adcsq_fifo_state_t;

    adcsq_fifo_state_t st;
    adcsq_fifo_state_t next_st;
    logic              push;
    logic              pop;

    assign inReady  = (st.count != (AW+1)'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData  = st.mem[st.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = (st.wrPtr == AW'(DEPTH-1)) ? '0 : st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == AW'(DEPTH-1)) ? '0 : st.rdPtr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    fifoBound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st.count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule : adcsq_fifo

module adcsq_sequencer #(
    parameter int unsigned RESET_DONE_CYCLES = `ADCSQ_RESET_DONE_CYC,
    parameter int unsigned ISO_READY_CYCLES  = `ADCSQ_ISO_READY_CYC,
    parameter int          FIFO_DEPTH        = 8
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Crystal input, shared output pin and interrupt
    input  wire logic                    crystal_input,
    output logic                         clock_out_or_sample_ready_pin,
    output logic                         irqN,
    // SPI
    input  wire logic                    sclk,
    input  wire logic                    csN,
    input  wire logic                    mosi,
    output logic                         miso,
    // Modulator sample stream
    input  wire logic                    sampleValid,
    output logic                         sampleReady,
    input  wire adcsq_pkg::adcsq_sample_t sampleData,
    // Analog front-end controls
    output logic                         currentInputShort,
    output logic                         currentInputIsolate,
    output logic                         isoSideReady
);
    adcsq_pkg::adcsq_state_t  st;
    adcsq_pkg::adcsq_state_t  next_st;
    adcsq_pkg::adcsq_cmd_t    cmd;
    adcsq_pkg::adcsq_sample_t fifoData;
    logic                     fifoValid;
    logic                     fifoPop;
    logic                     sclkRise;
    logic                     sclkFall;
    logic                     csFall;
    logic                     csRise;
    logic                     xtalRise;

    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
        crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `ADCSQ_CRC_POLY : 16'h0000);
    endfunction : crcStep

    function automatic logic [7:0] regRead(input adcsq_pkg::adcsq_state_t s,
                                           input logic [11:0] a);
        regRead = 8'h00;
        case (a)
            `ADCSQ_ISO_ACCESS_ADDR: regRead = s.isoAccess;
            `ADCSQ_SHORT_SEL_ADDR:  regRead = s.shortSel;
            `ADCSQ_MAIN_CONFIG_REG_ADDR:    regRead = s.main_config_reg;
            `ADCSQ_WR_LOCK_ADDR:    regRead = {7'h00, s.locked};
            `ADCSQ_PRIMARY_STATUS_REG_ADDR: begin
                regRead[`ADCSQ_RESET_DONE_BIT] = s.irqPending;
                regRead[`ADCSQ_FLOWING_BIT]    = s.flowing;
            end
            `ADCSQ_SECONDARY_STATUS_REG_ADDR: begin
                regRead[`ADCSQ_S1_SHORT_BIT] = s.shortSel[`ADCSQ_SHORT_BIT];
                regRead[`ADCSQ_S1_ISO_BIT]   = (s.pwr == adcsq_pkg::PWR_RUN);
            end
            default: regRead = 8'h00;
        endcase
    endfunction : regRead

    adcsq_fifo #(
        .WIDTH ($bits(adcsq_pkg::adcsq_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) sampleFifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   (sampleData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // ----------------------------------------------------------------
    // Edges of the synchronised pins
    // ----------------------------------------------------------------
    assign sclkRise = st.sclkS[1] && !st.sclkS[2];
    assign sclkFall = !st.sclkS[1] && st.sclkS[2];
    assign csFall   = !st.csS[1] && st.csS[2];
    assign csRise   = st.csS[1] && !st.csS[2];
    assign xtalRise = st.xtalS[1] && !st.xtalS[2];
    assign cmd      = st.cmd;
    // Drain only between transactions and between pulses, so the FIFO backs up
    assign fifoPop  = fifoValid && !st.pulseActive && st.csS[1]
                      && (st.pwr == adcsq_pkg::PWR_RUN);

    always_comb begin
        next_st = st;
        next_st.sclkS = {st.sclkS[1:0], sclk};
        next_st.csS   = {st.csS[1:0], csN};
        next_st.mosiS = {st.mosiS[0], mosi};
        next_st.xtalS = {st.xtalS[1:0], crystal_input};

        // Power-up timing
        if (st.pwr != adcsq_pkg::PWR_RUN) begin
            next_st.timer = st.timer + 24'h000001;
        end
        if (st.pwr == adcsq_pkg::PWR_WAIT && st.timer == 24'(RESET_DONE_CYCLES - 1)) begin
            next_st.pwr = adcsq_pkg::PWR_CTRL;
        end
        if (st.pwr == adcsq_pkg::PWR_CTRL && st.timer == 24'(ISO_READY_CYCLES - 1)) begin
            next_st.pwr = adcsq_pkg::PWR_RUN;
        end

        // Sample-ready pulse on each drained conversion
        if (st.pulseActive && xtalRise) begin
            next_st.pulseCnt = st.pulseCnt - 9'h001;
            if (st.pulseCnt == 9'h001) begin
                next_st.pulseActive = 1'b0;
            end
        end
        if (fifoPop) begin
            next_st.latest      = fifoData;
            next_st.flowing     = 1'b1;
            next_st.pulseActive = 1'b1;
            next_st.pulseCnt    = `ADCSQ_READY_PULSE_XTAL;
        end
        next_st.pinOut = st.main_config_reg[`ADCSQ_CLKOUT_BIT] ? st.xtalS[1]
                                                        : !st.pulseActive;

        // SPI response shifting and command capture
        if (sclkRise && !st.csS[1]) begin
            next_st.cmd = {st.cmd[30:0], st.mosiS[1]};
        end
        if (sclkFall && !st.csS[1]) begin
            next_st.bitCnt = st.bitCnt + 7'h01;
            next_st.resp   = {st.resp[126:0], 1'b0};
            if (st.bitCnt < `ADCSQ_RESP_BITS) begin
                next_st.crc = crcStep(st.crc, st.resp[127]);
            end
            if (st.bitCnt == `ADCSQ_RESP_BITS - 7'h01) begin
                next_st.resp = {crcStep(st.crc, st.resp[127]), 112'h0};
            end
        end
        if (csFall) begin
            next_st.resp   = {st.latest, 8'(regRead(st, `ADCSQ_PRIMARY_STATUS_REG_ADDR)),
                              regRead(st, `ADCSQ_SECONDARY_STATUS_REG_ADDR), st.readback, 32'h0};
            next_st.bitCnt = 7'h00;
            next_st.crc    = `ADCSQ_CRC_SEED;
        end

        // Commands are taken once the controller side is up
        if (csRise && st.pwr != adcsq_pkg::PWR_WAIT) begin
            next_st.readback = regRead(st, cmd.addr);
            if (cmd.write) begin
                case (cmd.addr)
                    `ADCSQ_ISO_ACCESS_ADDR:
                        next_st.isoAccess = {7'h00, cmd.data[`ADCSQ_PERMIT_BIT]};
                    `ADCSQ_SHORT_SEL_ADDR:
                        if (st.isoAccess[`ADCSQ_PERMIT_BIT]) begin
                            next_st.shortSel = {7'h00, cmd.data[`ADCSQ_SHORT_BIT]};
                        end
                    `ADCSQ_MAIN_CONFIG_REG_ADDR:
                        if (!st.locked) begin
                            next_st.main_config_reg = {7'h00, cmd.data[`ADCSQ_CLKOUT_BIT]};
                        end
                    `ADCSQ_WR_LOCK_ADDR:
                        if (cmd.data == `ADCSQ_LOCK_KEY) begin
                            next_st.locked = 1'b1;
                        end
                    `ADCSQ_PRIMARY_STATUS_REG_ADDR:
                        if (cmd.data[`ADCSQ_RESET_DONE_BIT]) begin
                            next_st.irqPending = 1'b0;
                        end
                    default: next_st.locked = st.locked;
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        if (st.pwr == adcsq_pkg::PWR_WAIT && st.timer == 24'(RESET_DONE_CYCLES - 1)) begin
            next_st.irqPending = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st        <= '0;
            st.csS    <= 3'h7;
            st.pinOut <= 1'b1;
            st.crc    <= `ADCSQ_CRC_SEED;
        end else begin
            st <= next_st;
        end
    end

    assign clock_out_or_sample_ready_pin = st.pinOut;
    assign irqN                = !st.irqPending;
    assign miso                = st.resp[127];
    assign currentInputShort   = st.shortSel[`ADCSQ_SHORT_BIT];
    assign currentInputIsolate = st.shortSel[`ADCSQ_SHORT_BIT];
    assign isoSideReady        = (st.pwr == adcsq_pkg::PWR_RUN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    resetDoneTime_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(st.pwr == adcsq_pkg::PWR_CTRL) |-> st.timer == 24'(RESET_DONE_CYCLES))
        else $error("Reset-complete at wrong time");
    isoReadyTime_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(isoSideReady) |-> st.timer == 24'(ISO_READY_CYCLES))
        else $error("Isolated side ready at wrong time");
    irqOnDone_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(st.pwr == adcsq_pkg::PWR_CTRL) |-> !irqN)
        else $error("Interrupt not raised by reset-complete");
    shortGate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(st.isoAccess[0]) |-> $stable(currentInputShort))
        else $error("Short changed without write permit");
    shortIsolate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        currentInputShort == currentInputIsolate)
        else $error("Short and isolation disagree");
    pulseStart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fifoPop && !st.main_config_reg[0] |=> st.pulseCnt == 9'h100
        ##1 !clock_out_or_sample_ready_pin) else $error("Sample-ready pulse did not start");
    flowingSticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(fifoPop) |-> st.flowing) else $error("Flowing flag not set");
    pinDefault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st.main_config_reg[0] && !$past(st.main_config_reg[0]) && !$past(st.pulseActive)
        |-> clock_out_or_sample_ready_pin) else $error("Pin not idle high");
    lockHolds_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(st.locked) |-> $stable(st.main_config_reg)) else $error("Locked config changed");
    crcLoad_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        csFall |=> st.bitCnt == 7'h00 && st.crc == 16'hFFFF)
        else $error("Response frame not restarted");

    shortEntered_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(currentInputShort));
    sampleFlow_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(st.flowing));
    fifoFull_c: cover property (@(posedge ref_clk) disable iff (!rst_n) !sampleReady);
    locked_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(st.locked));
endmodule : adcsq_sequencer

// ### verilog/adcsq_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the sequencer
// Assumes: ref_clk at 250 MHz
// Notes:   Included by the design file and the bench
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCSQ_ISO_ACCESS_ADDR   12'h005
`define ADCSQ_SHORT_SEL_ADDR    12'h0CC
`define ADCSQ_PRIMARY_STATUS_REG_ADDR      12'h002
`define ADCSQ_SECONDARY_STATUS_REG_ADDR      12'h003
`define ADCSQ_MAIN_CONFIG_REG_ADDR      12'h010
`define ADCSQ_WR_LOCK_ADDR      12'h01F

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define ADCSQ_PERMIT_BIT        0
`define ADCSQ_SHORT_BIT         0
`define ADCSQ_CLKOUT_BIT        0
`define ADCSQ_RESET_DONE_BIT    5
`define ADCSQ_FLOWING_BIT       4
`define ADCSQ_S1_SHORT_BIT      0
`define ADCSQ_S1_ISO_BIT        1
`define ADCSQ_LOCK_KEY          8'hD4
`define ADCSQ_REG_RESET         8'h00
`define ADCSQ_CRC_SEED          16'hFFFF
`define ADCSQ_CRC_POLY          16'h1021

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSQ_REF_CLK_KHZ       250000
`define ADCSQ_RESET_DONE_MS     32
`define ADCSQ_ISO_READY_MS      62
`define ADCSQ_RESET_DONE_CYC    (`ADCSQ_RESET_DONE_MS * `ADCSQ_REF_CLK_KHZ)
`define ADCSQ_ISO_READY_CYC     (`ADCSQ_ISO_READY_MS * `ADCSQ_REF_CLK_KHZ)
`define ADCSQ_READY_PULSE_XTAL  9'h100
`define ADCSQ_RESP_BITS         7'h60

`endif

// ### verilog/adcsq_pkg.sv
// Purpose: Types shared by the sequencer
// Assumes: Nothing
// Notes:   Constants live in adcsq_defs.svh
package adcsq_pkg;

    // Power-up sequence, Gray coded
    typedef enum logic [1:0] {
        PWR_WAIT = 2'h0,
        PWR_CTRL = 2'h1,
        PWR_RUN  = 2'h3
    } adcsq_pwr_t;

    typedef struct packed {
        logic [23:0] current;
        logic [23:0] voltage1;
        logic [23:0] voltage2;
    } adcsq_sample_t;

    typedef struct packed {
        logic        write;
        logic [2:0]  rsvd;
        logic [11:0] addr;
        logic [7:0]  data;
        logic [7:0]  crc;
    } adcsq_cmd_t;

    typedef struct packed {
        adcsq_pwr_t    pwr;
        logic [23:0]   timer;
        logic          irqPending;
        logic          flowing;
        logic [7:0]    isoAccess;
        logic [7:0]    shortSel;
        logic [7:0]    main_config_reg;
        logic          locked;
        logic [2:0]    sclkS;
        logic [2:0]    csS;
        logic [1:0]    mosiS;
        logic [2:0]    xtalS;
        logic [127:0]  resp;
        logic [31:0]   cmd;
        logic [6:0]    bitCnt;
        logic [15:0]   crc;
        logic [7:0]    readback;
        logic [8:0]    pulseCnt;
        logic          pulseActive;
        adcsq_sample_t latest;
        logic          pinOut;
    } adcsq_state_t;

endpackage : adcsq_pkg

// ### testbench/adcsq_host_model.sv
// Purpose: SPI main standing in for the host controller
// Assumes: Mode 0, SCLK idle low, 128-bit long frames
// Notes:   The command rides in the last 32 bits of each frame
`timescale 1ns/1ns

module adcsq_host_model #(
    parameter int HALF_NS = 24
) (
    // SPI
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    // ----------------------------------------------------------------
    // Frame transfer
    // ----------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end

    task automatic xfer(input logic [31:0] cmd, output logic [127:0] resp);
        csN = 1'b0;
        for (int i = 127; i >= 0; i--) begin
            mosi = (i < 32) ? cmd[i] : 1'b0;
            #(HALF_NS);
            sclk    = 1'b1;
            resp[i] = miso;
            #(HALF_NS);
            sclk = 1'b0;
        end
        #(HALF_NS);
        csN  = 1'b1;
        // Deselected line must not keep its last value
        mosi = ~mosi;
        #60;
    endtask : xfer
endmodule : adcsq_host_model

// ### testbench/adcsq_sequencer_test.sv
// Purpose: Self-checking bench of the sequencer through its SPI port
// Assumes: Shortened power-up counts of 50 and 100 cycles
// Notes:   Eight stream words are pushed before the isolated side is ready, the ninth once the first word is drained
`timescale 1ns/1ns
`include "adcsq_defs.svh"

module adcsq_sequencer_test;
    logic                     ref_clk;
    logic                     rst_n;
    logic                     crystal_input;
    logic                     pin;
    logic                     irqN;
    logic                     sclk;
    logic                     csN;
    logic                     mosi;
    logic                     miso;
    logic                     sampleValid;
    logic                     sampleReady;
    adcsq_pkg::adcsq_sample_t sampleData;
    logic                     shortOn;
    logic                     isolateOn;
    logic                     isoSideReady;
    logic [127:0]             rsp;
    logic [7:0]               rd;
    int                       nMismatch;
    int                       testsRun;

    adcsq_sequencer #(.RESET_DONE_CYCLES(50), .ISO_READY_CYCLES(100), .FIFO_DEPTH(8)) u_dut (
        .ref_clk                       (ref_clk),
        .rst_n                         (rst_n),
        .crystal_input                 (crystal_input),
        .clock_out_or_sample_ready_pin (pin),
        .irqN                          (irqN),
        .sclk                          (sclk),
        .csN                           (csN),
        .mosi                          (mosi),
        .miso                          (miso),
        .sampleValid                   (sampleValid),
        .sampleReady                   (sampleReady),
        .sampleData                    (sampleData),
        .currentInputShort             (shortOn),
        .currentInputIsolate           (isolateOn),
        .isoSideReady                  (isoSideReady)
    );

    adcsq_host_model u_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));

    // ----------------------------------------------------------------
    // Clocks
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial begin
        crystal_input = 1'b0;
        // 62 ns period, 16.129 MHz, inside the accepted crystal range
        forever #31 crystal_input = ~crystal_input;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic adcsq_pkg::adcsq_sample_t smp(input int i);
        return {24'hA00000 + 24'(i), 24'h500000 + 24'(i), 24'h0F0000 + 24'(i)};
    endfunction : smp

    function automatic logic [15:0] crc16(input logic [95:0] d);
        logic [15:0] c;
        c = `ADCSQ_CRC_SEED;
        for (int i = 95; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `ADCSQ_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc16

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_host.xfer({1'b1, 3'h0, a, d, 8'h00}, rsp);
    endtask : wr

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
        u_host.xfer({1'b0, 3'h0, a, 16'h0000}, rsp);
        u_host.xfer({1'b0, 3'h0, a, 16'h0000}, rsp);
        v = rsp[39:32];
        check("response crc", rsp[31:16], crc16(rsp[127:32]));
        check("response tail", rsp[15:0], 16'h0000);
    endtask : rd_reg

    task automatic push_words;
        int k;
        for (int i = 0; i < 9; i++) begin
            @(negedge ref_clk);
            sampleValid = 1'b1;
            sampleData  = smp(i);
            if (i == 8) begin
                check("ready when full", sampleReady, 1'b0);
            end
            for (k = 0; k < 20000 && sampleReady !== 1'b1; k++) begin
                @(negedge ref_clk);
            end
            if (k == 20000) begin
                nMismatch++;
                print_verdict();
            end
        end
        @(negedge ref_clk);
        sampleValid = 1'b0;
    endtask : push_words

    task automatic count_edges(output int n);
        logic last;
        n    = 0;
        last = pin;
        repeat (320) begin
            @(negedge ref_clk);
            if (pin !== last) begin
                n++;
            end
            last = pin;
        end
    endtask : count_edges

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int  n;
        int  k;
        int  hi;
        int  len;
        bit  seenHigh;
        time t0;
        nMismatch   = 0;
        testsRun    = 0;
        rst_n       = 1'b0;
        sampleValid = 1'b0;
        sampleData  = '0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        fork
            push_words();
        join_none
        repeat (20) @(negedge ref_clk);
        check("pin after reset", pin, 1'b1);
        check("irq after reset", irqN, 1'b1);
        check("short after reset", shortOn, 1'b0);
        check("iso ready early", isoSideReady, 1'b0);
        repeat (20) @(negedge ref_clk);
        check("irq before done", irqN, 1'b1);
        repeat (20) @(negedge ref_clk);
        check("irq at done", irqN, 1'b0);
        repeat (30) @(negedge ref_clk);
        check("iso ready before time", isoSideReady, 1'b0);
        repeat (20) @(negedge ref_clk);
        check("iso ready after time", isoSideReady, 1'b1);
        rd = 8'h00;
        for (k = 0; k < 20 && rd[`ADCSQ_RESET_DONE_BIT] !== 1'b1; k++) begin
            rd_reg(`ADCSQ_PRIMARY_STATUS_REG_ADDR, rd);
        end
        check("reset done flag", rd[`ADCSQ_RESET_DONE_BIT], 1'b1);
        rd_reg(`ADCSQ_ISO_ACCESS_ADDR, rd);
        check("permit reg reset", rd, `ADCSQ_REG_RESET);
        rd_reg(`ADCSQ_SECONDARY_STATUS_REG_ADDR, rd);
        check("iso ready status", rd[`ADCSQ_S1_ISO_BIT], 1'b1);
        $display("test power done");
        wr(`ADCSQ_PRIMARY_STATUS_REG_ADDR, 8'h20);
        check("irq after clear", irqN, 1'b1);

        wr(`ADCSQ_SHORT_SEL_ADDR, 8'h01);
        check("short without permit", shortOn, 1'b0);
        wr(`ADCSQ_ISO_ACCESS_ADDR, 8'h01);
        t0 = $time;
        hi       = 0;
        len      = 0;
        n        = 0;
        seenHigh = 1'b0;
        for (k = 0; k < 40000 && hi < 4000; k++) begin
            @(negedge ref_clk);
            if (pin === 1'b0) begin
                len++;
                hi = 0;
            end else begin
                if (len > 0 && seenHigh) begin
                    // 256 crystal periods of 15.5 cycles, one period of phase slack
                    check("pulse length", len >= 3950 && len <= 3972, 1'b1);
                    n++;
                end
                len      = 0;
                seenHigh = 1'b1;
                hi++;
            end
        end
        check("pulses seen", n > 0, 1'b1);
        check("ready after drain", sampleReady, 1'b1);
        rd_reg(`ADCSQ_PRIMARY_STATUS_REG_ADDR, rd);
        check("flowing flag", rd[`ADCSQ_FLOWING_BIT], 1'b1);
        check("wave samples", rsp[127:56], smp(8));
        $display("test stream done");

        while ($time - t0 < 200000) begin
            @(negedge ref_clk);
        end
        wr(`ADCSQ_SHORT_SEL_ADDR, 8'h01);
        check("short on", shortOn, 1'b1);
        check("isolate on", isolateOn, 1'b1);
        repeat (50) @(negedge ref_clk);
        rd_reg(`ADCSQ_SECONDARY_STATUS_REG_ADDR, rd);
        check("short status", rd[`ADCSQ_S1_SHORT_BIT], 1'b1);
        wr(`ADCSQ_SHORT_SEL_ADDR, 8'h00);
        check("short off", shortOn, 1'b0);
        check("isolate off", isolateOn, 1'b0);
        wr(`ADCSQ_ISO_ACCESS_ADDR, 8'h00);
        wr(`ADCSQ_SHORT_SEL_ADDR, 8'h01);
        check("short after revoke", shortOn, 1'b0);
        $display("test offset done");

        wr(`ADCSQ_MAIN_CONFIG_REG_ADDR, 8'h01);
        count_edges(n);
        check("clock out toggles", n >= 30, 1'b1);
        wr(`ADCSQ_MAIN_CONFIG_REG_ADDR, 8'h00);
        repeat (8) @(negedge ref_clk);
        check("ready pin idle", pin, 1'b1);
        wr(`ADCSQ_WR_LOCK_ADDR, `ADCSQ_LOCK_KEY);
        wr(`ADCSQ_MAIN_CONFIG_REG_ADDR, 8'h01);
        count_edges(n);
        check("config locked", n == 0, 1'b1);
        rd_reg(`ADCSQ_WR_LOCK_ADDR, rd);
        check("lock flag", rd[0], 1'b1);
        $display("test config done");
        print_verdict();
    end
endmodule : adcsq_sequencer_test
